// [bench/pms_host_model.sv]
// SMBus host model: pulls SCL or SDA low, or lets them float high.
// Assumes the bench wires each line as a pulled-up wired AND.
`timescale 1ns/10ps
module pms_host_model (
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_low = 1'h0,
   output logic      sda_low = 1'h0
);
   int n_to = 0;
   // One 64 ns clock: s is SDA before the rise, p after the sample.
   // A start is (1,0), a stop (0,1); SCL stays released after a stop.
   task bit_io(input logic s, input logic p, output logic q);
      #16 sda_low = ~s;
      #16 scl_low = 1'h0;
      for (int i = 0; i < 64 && scl !== 1'h1; i++) #4;
      if (scl !== 1'h1) n_to++;
      #16 q = sda;
      sda_low = ~p;
      #16 scl_low = s | ~p;
   endtask
endmodule // pms_host_model

// [bench/pms_monitor_port_tb.sv]
// Self-checking bench of the PMBus monitor and status port.
// Assumes the package, interface, design and host model compile first.
`timescale 1ns/10ps
`include "pms_consts.svh"
`define CHK(g, w) begin num_checks++; if ((g) !== (w)) begin n_errors++; \
 $display("Error at %0t: got %h want %h", $time, g, w); end end
module pms_monitor_port_tb;
   localparam int TEL = 2000, INI = 400;
   logic        core_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
   logic        pwrite = 1'h0, err, irq, init_done, pready, pslverr, a, b;
   logic        scl_oe, sda_oe, al_oe, scl_low, sda_low;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [47:0] ev = 48'h0;
   logic [15:0] v, meas [4] = '{16'h1234, 16'h2345, 16'h3456, 16'h4567};
   logic [7:0]  cmds [4] = '{`PMS_CMD_VIN, `PMS_CMD_VOUT, `PMS_CMD_IOUT,
                             `PMS_CMD_TEMP};
   wire         scl = ~(scl_low | scl_oe);
   wire         sda = ~(sda_low | sda_oe);
   int          n_errors = 0, num_checks = 0;
   // Strap index 5 gives target address 7'h65; power stays good.
   pms_monitor_port #(.TEL_CYC(TEL), .INIT_CYC(INI)) dut (
      .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .scl_in(scl), .scl_out(), .scl_oe,
      .sda_in(sda), .sda_out(), .sda_oe, .fault_alert_line_in(~al_oe),
      .fault_alert_line_out(), .fault_alert_line_oe(al_oe),
      .addr_strap(4'h5), .power_good_signal(1'h1), .fault_events(ev),
      .vin_meas(meas[0]), .vout_meas(meas[1]), .iout_meas(meas[2]),
      .hot_spot_temp(meas[3]), .init_done, .irq);
   pms_host_model host (.scl, .sda, .scl_low, .sda_low);
   // Free-running 250 MHz clock.
   always #2 core_clk = ~core_clk;
   // Counts, verdict and the end of the run.
   task end_sim;
      $display("Checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // One APB transfer, held until pready is seen high at a rising edge.
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      int i;
      @(posedge core_clk) {psel, pwrite, paddr, pwdata} <= {1'h1, w, ad, d};
      @(posedge core_clk) penable <= 1'h1;
      for (i = 0; i < 16 && pready !== 1'h1; i++) @(posedge core_clk);
      if (i == 16) begin n_errors++; end_sim(); end
      {q, err} = {prdata, pslverr};
      {psel, penable} <= 2'h0;
   endtask
   // Command to the target; with rd set, a two-byte read follows.
   // Bits sampled back overwrite the sent ones, so acks land in place.
   task smb(input logic [7:0] c, input logic rd);
      logic [17:0] w;
      logic [26:0] r;
      w = {8'hCA, 1'h1, c, 1'h1};
      r = {8'hCB, 1'h1, 8'hFF, 1'h0, 8'hFF, 1'h1};
      #1.37 host.bit_io(1'h1, 1'h0, b);
      for (int k = 17; k >= 0; k--) host.bit_io(w[k], w[k], w[k]);
      a = !(w[9] | w[0]);
      if (rd) host.bit_io(1'h1, 1'h0, b);
      for (int k = 26; rd && k >= 0; k--) host.bit_io(r[k], r[k], r[k]);
      v = {r[8:1], r[17:10]};
      host.bit_io(1'h0, 1'h1, b);
      #1300;
      if (host.n_to != 0) begin n_errors++; end_sim(); end
   endtask
   // Reset values, strap address, unmapped access, BUSY before init.
   task boot;
      repeat (8) @(posedge core_clk);
      `CHK(init_done, 1'h0)
      apb(1'h0, `PMS_A_CTRL, 32'h0);
      `CHK(q, 32'h00000060)
      apb(1'h0, `PMS_A_ADDR, 32'h0);
      `CHK(q, 32'h00000065)
      apb(1'h0, 12'h014, 32'h0);
      `CHK({err, q}, 33'h100000000)
      apb(1'h1, `PMS_A_IRQ_MK, 32'h1);
      smb(`PMS_CMD_VIN, 1'h0);
      `CHK(a, 1'h0)
      smb(`PMS_CMD_ST_BYTE, 1'h1);
      `CHK({init_done, v, al_oe}, 18'h3FF01)
   endtask
   // A one-cycle vout event stays latched until clear-faults.
   task fault;
      @(posedge core_clk) ev <= 48'h1;
      @(posedge core_clk) ev <= 48'h0;
      repeat (3) @(posedge core_clk);
      `CHK({al_oe, irq}, 2'h3)
      smb(`PMS_CMD_ST_WORD, 1'h1);
      `CHK(v, 16'h80A0)
      smb(`PMS_CMD_ST_VOUT, 1'h1);
      `CHK(v, 16'hFF01)
      apb(1'h1, `PMS_A_IRQ_ST, 32'h7);
      smb(`PMS_CMD_CLEAR, 1'h0);
      `CHK(a, 1'h1)
      apb(1'h0, `PMS_A_IRQ_ST, 32'h0);
      `CHK(q, 32'h00000002)
      smb(`PMS_CMD_ST_WORD, 1'h1);
      `CHK({v, al_oe, irq}, 18'h0)
   endtask
   // Each reading, then a changed input shows after one refresh.
   // An unknown command is refused and lands in the CML byte.
   task telem;
      for (int k = 0; k < 4; k++) begin
         smb(cmds[k], 1'h1);
         `CHK(v, meas[k])
      end
      @(posedge core_clk) meas[0] <= 16'hABCD;
      repeat (TEL + 4) @(posedge core_clk);
      smb(`PMS_CMD_VIN, 1'h1);
      `CHK(v, 16'hABCD)
      smb(8'h55, 1'h0);
      `CHK(a, 1'h0)
      smb(`PMS_CMD_ST_CML, 1'h1);
      `CHK(v, 16'hFF80)
   endtask
   // Reset for 20 cycles, then the scenarios in turn.
   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'h1;
      boot();
      fault();
      telem();
      end_sim();
   end
endmodule // pms_monitor_port_tb

// [src/pms_consts.svh]
// Constants of the PMBus monitor and status port.
// Assumes it is included by bare name from the src files.
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH
`define PMS_CLK_NS      4
`define PMS_TELEM_NS    250000
`define PMS_INIT_MS     30
`define PMS_BUS_FREE_NS 1300
`define PMS_BASE_ADDR   7'h60
`define PMS_NCAT        6
`define PMS_CAT_CML     4
`define PMS_CMD_CLEAR   8'h03
`define PMS_CMD_ST_BYTE 8'h78
`define PMS_CMD_ST_WORD 8'h79
`define PMS_CMD_ST_VOUT 8'h7A
`define PMS_CMD_ST_IOUT 8'h7B
`define PMS_CMD_ST_IN   8'h7C
`define PMS_CMD_ST_TEMP 8'h7D
`define PMS_CMD_ST_CML  8'h7E
`define PMS_CMD_ST_MFR  8'h80
`define PMS_CMD_VIN     8'h88
`define PMS_CMD_VOUT    8'h8B
`define PMS_CMD_IOUT    8'h8C
`define PMS_CMD_TEMP    8'h8D
`define PMS_CML_BAD_CMD 7
`define PMS_CML_BAD_DAT 6
`define PMS_A_CTRL      12'h000
`define PMS_A_STATUS    12'h004
`define PMS_A_IRQ_ST    12'h008
`define PMS_A_IRQ_MK    12'h00C
`define PMS_A_ADDR      12'h010
`define PMS_IRQ_FAULT   0
`define PMS_IRQ_CLEAR   1
`define PMS_IRQ_COMM    2
`endif

// [src/pms_monitor_port.sv]
// PMBus monitor and status port: telemetry, sticky status, APB view.
// Assumes fault_events, measurements and power_good_signal come from
// core_clk logic; SCL, SDA and the strap are raw pins.
// What this block does
// - Standard SMBus transactions; target stretches SCL, host waits.
// - Requests refused while busy latch the BUSY status bit.
// - Input voltage, output voltage, current, temperature readable.
// - Telemetry snapshot refreshed every 0.25 ms.
// - Status split into summary byte/word and category bytes.
// - Category and BUSY status bits stay latched until clear-faults command 0x03.
// - Output re-enable never clears latched status; only clear-faults.
// - Bus clock 100 to 400 kHz must work.
// - Ready about 30 ms after control supply comes up.
// - Temperature taken from the hot-spot sensor input.
// - No packet error checking byte generated or checked.
// - Open-drain alert line flags latched faults.
// - Target address is base (default 0x60) plus strap index.
`timescale 1ns/10ps
`include "pms_consts.svh"
module pms_monitor_port #(
   parameter int TEL_CYC  = `PMS_TELEM_NS / `PMS_CLK_NS,
   parameter int INIT_CYC = `PMS_INIT_MS * 1000000 / `PMS_CLK_NS
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic        fault_alert_line_in,
   output logic             fault_alert_line_out,
   output logic             fault_alert_line_oe,
   input  wire logic [3:0]  addr_strap,
   input  wire logic        power_good_signal,
   input  wire logic [47:0] fault_events,
   input  wire logic [15:0] vin_meas,
   input  wire logic [15:0] vout_meas,
   input  wire logic [15:0] iout_meas,
   input  wire logic [15:0] hot_spot_temp,
   output logic             init_done,
   output logic             irq
);
   localparam logic [15:0] TEL_LAST  = 16'(TEL_CYC - 1);
   localparam logic [22:0] INIT_LAST = 23'(INIT_CYC - 1);

   pms_pkg::pms_core_type st;
   pms_pkg::pms_core_type next_st;
   pms_smb_if             bus ();
   logic [5:0][7:0]       ext_ev;
   logic [5:0][7:0]       ev_cat;
   logic [5:0][7:0]       cat_next;
   logic [7:0]            cml_ev;
   logic                  busy_ev;
   logic                  clear_now;
   logic                  next_accept;
   logic                  is_status;
   logic                  known;
   logic [15:0]           status_word;
   logic [15:0]           rd_w;
   logic                  rd_two;
   logic                  apb_wr;
   logic                  mapped;
   logic [2:0]            w1c;
   logic [2:0]            irq_ev;

   // The alert, clock and data pins only ever pull low.
   assign scl_out              = 1'b0;
   assign sda_out              = 1'b0;
   assign fault_alert_line_out = 1'b0;
   assign fault_alert_line_oe  = st.alert;
   assign init_done            = st.init_done;
   assign irq                  = st.irq;
   assign ext_ev               = fault_events;
   assign bus.own_addr = st.base + {3'h0, st.strap_idx};
   assign bus.accept   = st.accept;
   assign bus.rd_data  = st.rd_data;
   assign bus.rd_ready = st.rd_ready;

   pms_smb_target u_engine (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .scl_oe   (scl_oe),
      .sda_oe   (sda_oe),
      .bus      (bus.engine)
   );

   // Summary byte: busy, off, vout, iout, input, temp, cml, other.
   // Word high byte: vout, iout, input, mfr, power-good low.
   assign status_word = {|st.cat[0], |st.cat[1], |st.cat[2],
                         |st.cat[5], ~power_good_signal, 3'h0,
                         st.busy_l, 1'b0, |st.cat[0], |st.cat[1],
                         |st.cat[2], |st.cat[3], |st.cat[4],
                         |st.cat[5] | ~power_good_signal};

   // Command decode. Status reads stay open while busy so that the host
   // can still see why it was refused.
   always_comb begin
      is_status = 1'b0;
      known     = 1'b1;
      case (bus.rx_byte)
         `PMS_CMD_ST_BYTE, `PMS_CMD_ST_WORD, `PMS_CMD_ST_VOUT,
         `PMS_CMD_ST_IOUT, `PMS_CMD_ST_IN, `PMS_CMD_ST_TEMP,
         `PMS_CMD_ST_CML, `PMS_CMD_ST_MFR: is_status = 1'b1;
         `PMS_CMD_CLEAR, `PMS_CMD_VIN, `PMS_CMD_VOUT, `PMS_CMD_IOUT,
         `PMS_CMD_TEMP: known = 1'b1;
         default: known = 1'b0;
      endcase
   end

   always_comb begin
      clear_now   = 1'b0;
      busy_ev     = 1'b0;
      cml_ev      = 8'h00;
      next_accept = st.accept;
      if (bus.cmd_valid) begin
         if (!st.init_done && !is_status) begin
            next_accept = 1'b0;
            busy_ev     = 1'b1;
         end else if (!known) begin
            next_accept                = 1'b0;
            cml_ev[`PMS_CML_BAD_CMD]   = 1'b1;
         end else begin
            next_accept = 1'b1;
            clear_now   = (bus.rx_byte == `PMS_CMD_CLEAR);
         end
      end
      // No command here takes data, so written bytes are refused.
      if (bus.wr_valid) begin
         next_accept              = 1'b0;
         cml_ev[`PMS_CML_BAD_DAT] = 1'b1;
      end
   end

   // Read data per command; words go low byte first, then 0xFF filler.
   always_comb begin
      rd_w   = 16'hFFFF;
      rd_two = 1'b0;
      case (st.cmd)
         `PMS_CMD_ST_BYTE: rd_w[7:0] = status_word[7:0];
         `PMS_CMD_ST_WORD: begin
            rd_w   = status_word;
            rd_two = 1'b1;
         end
         `PMS_CMD_ST_VOUT: rd_w[7:0] = st.cat[0];
         `PMS_CMD_ST_IOUT: rd_w[7:0] = st.cat[1];
         `PMS_CMD_ST_IN:   rd_w[7:0] = st.cat[2];
         `PMS_CMD_ST_TEMP: rd_w[7:0] = st.cat[3];
         `PMS_CMD_ST_CML:  rd_w[7:0] = st.cat[4];
         `PMS_CMD_ST_MFR:  rd_w[7:0] = st.cat[5];
         // The low code bits do not follow the snapshot order, so each
         // reading command picks its own slot.
         `PMS_CMD_VIN: begin
            rd_w   = st.tel[0];
            rd_two = 1'b1;
         end
         `PMS_CMD_VOUT: begin
            rd_w   = st.tel[1];
            rd_two = 1'b1;
         end
         `PMS_CMD_IOUT: begin
            rd_w   = st.tel[2];
            rd_two = 1'b1;
         end
         `PMS_CMD_TEMP: begin
            rd_w   = st.tel[3];
            rd_two = 1'b1;
         end
         default: rd_w = 16'hFFFF;
      endcase
   end

   // Each category latches its events; a clear in the same cycle as an
   // event keeps the event, so nothing is lost across a clear.
   genvar gi;
   generate
      for (gi = 0; gi < `PMS_NCAT; gi++) begin : g_cat
         assign ev_cat[gi] = ext_ev[gi]
                           | ((gi == `PMS_CAT_CML) ? cml_ev : 8'h00);
         assign cat_next[gi] = (clear_now ? 8'h00 : st.cat[gi])
                             | ev_cat[gi];
      end
   endgenerate

   // APB decode: zero wait, read data captured in the setup cycle, writes taken in the access cycle.
   assign pready  = psel & penable;
   assign apb_wr  = psel & penable & pwrite;
   assign mapped  = (paddr == `PMS_A_CTRL) || (paddr == `PMS_A_STATUS)
                 || (paddr == `PMS_A_IRQ_ST) || (paddr == `PMS_A_IRQ_MK)
                 || (paddr == `PMS_A_ADDR);
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = st.prdata;
   assign w1c     = (apb_wr && paddr == `PMS_A_IRQ_ST) ? pwdata[2:0]
                                                       : 3'h0;
   assign irq_ev  = {(cml_ev != 8'h00) | busy_ev, clear_now,
                     ext_ev != 48'h0};

   // Core state update.
   always_comb begin
      next_st         = st;
      next_st.strap_a = addr_strap;
      next_st.strap_b = st.strap_a;
      // The strap is followed until ready, then frozen.
      if (!st.init_done) begin
         next_st.strap_idx = st.strap_b;
         next_st.init_cnt  = st.init_cnt + 23'h1;
         next_st.init_done = (st.init_cnt == INIT_LAST);
      end
      // Host reads see a stable snapshot between refreshes.
      if (st.tel_cnt == TEL_LAST) begin
         next_st.tel_cnt = 16'h0;
         next_st.tel     = {hot_spot_temp, iout_meas, vout_meas,
                            vin_meas};
      end else begin
         next_st.tel_cnt = st.tel_cnt + 16'h1;
      end
      if (bus.cmd_valid) begin
         next_st.cmd = bus.rx_byte;
      end
      next_st.accept   = next_accept;
      next_st.rd_ready = bus.rd_req;
      if (bus.rd_req) begin
         if (bus.rd_index == 4'h0) begin
            next_st.rd_data = rd_w[7:0];
         end else if (bus.rd_index == 4'h1 && rd_two) begin
            next_st.rd_data = rd_w[15:8];
         end else begin
            next_st.rd_data = 8'hFF;
         end
      end
      next_st.cat    = cat_next;
      next_st.busy_l = (st.busy_l & ~clear_now) | busy_ev;
      next_st.alert  = (cat_next != 48'h0) | next_st.busy_l;
      next_st.irq_st = (st.irq_st & ~w1c) | irq_ev;
      if (apb_wr && paddr == `PMS_A_CTRL) begin
         next_st.base = pwdata[6:0];
      end
      if (apb_wr && paddr == `PMS_A_IRQ_MK) begin
         next_st.irq_mk = pwdata[2:0];
      end
      next_st.irq = |(next_st.irq_st & next_st.irq_mk);
      if (psel && !penable) begin
         case (paddr)
            `PMS_A_CTRL:   next_st.prdata = {25'h0, st.base};
            `PMS_A_STATUS: next_st.prdata = {15'h0, st.init_done,
                                             status_word};
            `PMS_A_IRQ_ST: next_st.prdata = {29'h0, st.irq_st};
            `PMS_A_IRQ_MK: next_st.prdata = {29'h0, st.irq_mk};
            `PMS_A_ADDR:   next_st.prdata = {25'h0, bus.own_addr};
            default:       next_st.prdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st      <= '0;
         st.base <= `PMS_BASE_ADDR;
      end else begin
         st <= next_st;
      end
   end

   a_clear_empties: assert property (@(posedge core_clk) disable iff
      (!rst_n) (clear_now && ext_ev == 48'h0) |=> (st.cat == 48'h0)
      && !st.busy_l) else $error("clear-faults left bits set");
   a_clear_flag: assert property (@(posedge core_clk) disable iff
      (!rst_n) clear_now |=> st.irq_st[`PMS_IRQ_CLEAR])
      else $error("clear-faults did not flag its interrupt");
   a_status_sticky: assert property (@(posedge core_clk) disable iff
      (!rst_n) !clear_now |=> (($past(st.cat) & ~st.cat) == 48'h0))
      else $error("status bit fell without clear");
   a_event_sets: assert property (@(posedge core_clk) disable iff
      (!rst_n) 1'b1 |=> ((st.cat & $past(ev_cat)) == $past(ev_cat)))
      else $error("event did not set its status bit");
   a_tel_refresh: assert property (@(posedge core_clk) disable iff
      (!rst_n) (st.tel_cnt == TEL_LAST) |=> (st.tel[0] == $past(vin_meas))
      && (st.tel[3] == $past(hot_spot_temp)) && (st.tel_cnt == 16'h0))
      else $error("telemetry not refreshed on period");
   a_tel_stable: assert property (@(posedge core_clk) disable iff
      (!rst_n) (st.tel_cnt != TEL_LAST) |=> $stable(st.tel))
      else $error("telemetry changed mid period");
   a_busy_refuse: assert property (@(posedge core_clk) disable iff
      (!rst_n) (bus.cmd_valid && !st.init_done && !is_status)
      |=> !bus.accept && st.busy_l && fault_alert_line_oe)
      else $error("busy request not refused");
   a_alert_level: assert property (@(posedge core_clk) disable iff
      (!rst_n) (st.cat != 48'h0) |-> fault_alert_line_oe)
      else $error("alert not driven with latched fault");
   a_read_answer: assert property (@(posedge core_clk) disable iff
      (!rst_n) bus.rd_req |=> bus.rd_ready ##1 !bus.rd_ready)
      else $error("read byte not answered in one cycle");
   a_init_time: assert property (@(posedge core_clk) disable iff
      (!rst_n) $rose(st.init_done) |-> ($past(st.init_cnt) == INIT_LAST))
      else $error("ready came at the wrong count");
endmodule // pms_monitor_port

// [src/pms_pkg.sv]
// Types of the PMBus monitor and status port.
// Assumes nothing beyond a SystemVerilog compiler.
package pms_pkg;
   typedef enum logic [2:0] {
      PMS_IDLE = 3'b000,
      PMS_ADDR = 3'b001,
      PMS_CMD  = 3'b010,
      PMS_WDAT = 3'b011,
      PMS_TX   = 3'b100
   } pms_state_type;

   typedef struct packed {
      logic [2:0]    scl_s;
      logic [2:0]    sda_s;
      pms_state_type state;
      logic [3:0]    bitcnt;
      logic [7:0]    shift;
      logic          rnw;
      logic          ack;
      logic          sda_oe;
      logic          scl_hold;
      logic          cmd_valid;
      logic          wr_valid;
      logic          rd_req;
      logic [3:0]    byte_idx;
      logic          stop_seen;
   } pms_eng_type;

   typedef struct packed {
      logic [3:0]       strap_a;
      logic [3:0]       strap_b;
      logic [3:0]       strap_idx;
      logic [6:0]       base;
      logic [22:0]      init_cnt;
      logic             init_done;
      logic [15:0]      tel_cnt;
      logic [3:0][15:0] tel;
      logic [5:0][7:0]  cat;
      logic             busy_l;
      logic [7:0]       cmd;
      logic             accept;
      logic [7:0]       rd_data;
      logic             rd_ready;
      logic [2:0]       irq_st;
      logic [2:0]       irq_mk;
      logic [31:0]      prdata;
      logic             alert;
      logic             irq;
   } pms_core_type;
endpackage

// [src/pms_smb_if.sv]
// Byte-level link between the serial engine and the status core.
// Assumes both ends run on core_clk.
`timescale 1ns/10ps
interface pms_smb_if;
   logic [6:0] own_addr;
   logic       cmd_valid;
   logic       wr_valid;
   logic [7:0] rx_byte;
   logic       rd_req;
   logic [3:0] rd_index;
   logic [7:0] rd_data;
   logic       rd_ready;
   logic       accept;
   logic       stop_seen;
   modport engine (input own_addr, rd_data, rd_ready, accept,
                   output cmd_valid, wr_valid, rx_byte, rd_req,
                   rd_index, stop_seen);
   modport core (output own_addr, rd_data, rd_ready, accept,
                 input cmd_valid, wr_valid, rx_byte, rd_req,
                 rd_index, stop_seen);
endinterface

// [src/pms_smb_target.sv]
// SMBus target bit engine: start/stop, address match, byte shifting.
// Assumes SCL and SDA are raw pins and the core answers a read
// request within a few cycles while SCL is held low.
`timescale 1ns/10ps
module pms_smb_target (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      scl_oe,
   output logic      sda_oe,
   pms_smb_if.engine bus
);
   pms_pkg::pms_eng_type st;
   pms_pkg::pms_eng_type next_st;
   logic scl_v;
   logic sda_v;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;

   // Stage 0 feeds only stage 1; edges compare stage 1 with stage 2.
   // At 4 ns sampling even 400 kHz leaves over 300 samples per phase.
   assign scl_v    = st.scl_s[1];
   assign sda_v    = st.sda_s[1];
   assign scl_rise = scl_v & ~st.scl_s[2];
   assign scl_fall = ~scl_v & st.scl_s[2];
   assign start_c  = scl_v & st.scl_s[2] & ~sda_v & st.sda_s[2];
   assign stop_c   = scl_v & st.scl_s[2] & sda_v & ~st.sda_s[2];

   assign scl_oe        = st.scl_hold;
   assign sda_oe        = st.sda_oe;
   assign bus.cmd_valid = st.cmd_valid;
   assign bus.wr_valid  = st.wr_valid;
   assign bus.rx_byte   = st.shift;
   assign bus.rd_req    = st.rd_req;
   assign bus.rd_index  = st.byte_idx;
   assign bus.stop_seen = st.stop_seen;

   // Bit sequencing; a start anywhere restarts the frame, the idle gap
   // before it is not timed here.
   always_comb begin
      next_st           = st;
      next_st.scl_s     = {st.scl_s[1:0], scl_in};
      next_st.sda_s     = {st.sda_s[1:0], sda_in};
      next_st.cmd_valid = 1'b0;
      next_st.wr_valid  = 1'b0;
      next_st.rd_req    = 1'b0;
      next_st.stop_seen = 1'b0;
      if (start_c) begin
         next_st.state    = pms_pkg::PMS_ADDR;
         next_st.bitcnt   = 4'h0;
         next_st.sda_oe   = 1'b0;
         next_st.scl_hold = 1'b0;
      end else if (stop_c) begin
         next_st.state     = pms_pkg::PMS_IDLE;
         next_st.sda_oe    = 1'b0;
         next_st.scl_hold  = 1'b0;
         next_st.stop_seen = 1'b1;
      end else if (st.state == pms_pkg::PMS_TX) begin
         if (st.scl_hold && bus.rd_ready) begin
            next_st.shift    = bus.rd_data;
            next_st.sda_oe   = ~bus.rd_data[7];
            next_st.scl_hold = 1'b0;
         end else if (scl_fall && st.bitcnt < 4'h7) begin
            next_st.shift  = {st.shift[6:0], 1'b0};
            next_st.sda_oe = ~st.shift[6];
            next_st.bitcnt = st.bitcnt + 4'h1;
         end else if (scl_fall && st.bitcnt == 4'h7) begin
            next_st.sda_oe = 1'b0;
            next_st.bitcnt = 4'h8;
         end else if (scl_rise && st.bitcnt == 4'h8) begin
            // A host NACK ends the read; no check byte follows.
            if (sda_v) begin
               next_st.state = pms_pkg::PMS_IDLE;
            end else begin
               next_st.bitcnt = 4'h9;
            end
         end else if (scl_fall && st.bitcnt == 4'h9) begin
            next_st.bitcnt   = 4'h0;
            next_st.byte_idx = st.byte_idx + 4'h1;
            next_st.rd_req   = 1'b1;
            next_st.scl_hold = 1'b1;
         end
      end else if (st.state != pms_pkg::PMS_IDLE) begin
         if (scl_rise && st.bitcnt < 4'h8) begin
            next_st.shift  = {st.shift[6:0], sda_v};
            next_st.bitcnt = st.bitcnt + 4'h1;
            if (st.bitcnt == 4'h7) begin
               next_st.cmd_valid = (st.state == pms_pkg::PMS_CMD);
               next_st.wr_valid  = (st.state == pms_pkg::PMS_WDAT);
            end
         end else if (scl_fall && st.bitcnt == 4'h8) begin
            next_st.bitcnt = 4'h9;
            if (st.state == pms_pkg::PMS_ADDR) begin
               next_st.ack = (st.shift[7:1] == bus.own_addr);
               next_st.rnw = st.shift[0];
            end else begin
               next_st.ack = bus.accept;
            end
            next_st.sda_oe = next_st.ack;
         end else if (scl_fall && st.bitcnt == 4'h9) begin
            next_st.sda_oe = 1'b0;
            next_st.bitcnt = 4'h0;
            if (!st.ack) begin
               next_st.state = pms_pkg::PMS_IDLE;
            end else if (st.state == pms_pkg::PMS_ADDR && st.rnw) begin
               next_st.state    = pms_pkg::PMS_TX;
               next_st.rd_req   = 1'b1;
               next_st.scl_hold = 1'b1;
               next_st.byte_idx = 4'h0;
            end else if (st.state == pms_pkg::PMS_ADDR) begin
               next_st.state = pms_pkg::PMS_CMD;
            end else begin
               next_st.state = pms_pkg::PMS_WDAT;
            end
         end
      end
   end

   // Lines idle high, so the synchronisers reset to one.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st       <= '0;
         st.scl_s <= 3'h7;
         st.sda_s <= 3'h7;
      end else begin
         st <= next_st;
      end
   end

   a_stretch_release: assert property (@(posedge core_clk) disable iff
      (!rst_n) (st.scl_hold && bus.rd_ready && !start_c && !stop_c)
      |=> !scl_oe && (sda_oe == !$past(bus.rd_data[7])))
      else $error("stretch not released on read data");
   a_addr_ack: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st.state == pms_pkg::PMS_ADDR && st.bitcnt == 4'h8 && scl_fall
       && !start_c && !stop_c) |=> (sda_oe == (st.shift[7:1] == bus.own_addr)))
      else $error("address acknowledge wrong");
endmodule // pms_smb_target
